// ==== hw/ies_pkg.sv ====
package ies_pkg;

  // ********************************************************************
  // timing and sizes
  // ********************************************************************
  localparam int unsigned OSC_PER_INSN = 4; // clock periods per instruction cycle
  localparam int unsigned STACK_DEPTH = 8;
  localparam int unsigned PC_W = 13;
  localparam int unsigned WORD_W = 14;

  // ********************************************************************
  // register offsets (byte addresses, one word each)
  // ********************************************************************
  localparam logic [11:0] A_CTRL = 12'h000;
  localparam logic [11:0] A_STATUS = 12'h004;
  localparam logic [11:0] A_ACC = 12'h008;
  localparam logic [11:0] A_PC = 12'h00C;
  localparam logic [11:0] A_UJL = 12'h010;
  localparam logic [11:0] A_STACK = 12'h014;

  // ********************************************************************
  // field positions
  // ********************************************************************
  localparam int unsigned CTRL_RUN_BIT = 0;
  localparam int unsigned CTRL_CLR_BIT = 1;
  localparam int unsigned ST_C_BIT = 0;
  localparam int unsigned ST_DC_BIT = 1;
  localparam int unsigned ST_Z_BIT = 2;
  localparam int unsigned ST_ILL_BIT = 3;
  localparam int unsigned ST_PH_LSB = 4;
  localparam int unsigned STK_TOP_LSB = 16;
  localparam int unsigned DEST_BIT = 7;
  localparam int unsigned UJL_HI = 4;
  localparam int unsigned UJL_LO = 3;

  // ********************************************************************
  // reset values
  // ********************************************************************
  localparam logic [PC_W-1:0] RST_PC = 13'h0000;
  localparam logic [7:0] RST_W = 8'h00;
  localparam logic [4:0] RST_UJL = 5'h00;
  localparam logic [WORD_W-1:0] NOP_WORD = 14'h0000;

  // ********************************************************************
  // opcode patterns (x bits simply left out of the compare)
  // ********************************************************************
  localparam logic [4:0] OPC_ADD_LIT = 5'h1F;  // word[13:9]
  localparam logic [5:0] OPC_AND_LIT = 6'h39;  // word[13:8]
  localparam logic [5:0] OPC_ADD_FILE = 6'h07; // word[13:8]
  localparam logic [5:0] OPC_AND_FILE = 6'h05; // word[13:8]
  localparam logic [3:0] OPC_BIT_SKIP = 4'h7;  // word[13:10]
  localparam logic [2:0] OPC_CALL = 3'h4;      // word[13:11]
  localparam logic [6:0] OPC_CLR_FILE = 7'h03; // word[13:7]
  localparam logic [5:0] OPC_DEC_SKIP = 6'h0B; // word[13:8]

  typedef enum logic [3:0] {
    OP_NOP = 4'h0,
    OP_ADD_LIT = 4'h1,
    OP_AND_LIT = 4'h2,
    OP_ADD_FILE = 4'h3,
    OP_AND_FILE = 4'h4,
    OP_BIT_SKIP = 4'h5,
    OP_CALL = 4'h6,
    OP_CLR_FILE = 4'h7,
    OP_DEC_SKIP = 4'h8,
    OP_OTHER = 4'h9
  } ies_op_t;

  typedef enum logic [1:0] {
    PH_Q1 = 2'h0,
    PH_Q2 = 2'h1,
    PH_Q3 = 2'h2,
    PH_Q4 = 2'h3
  } ies_phase_t;

  typedef enum logic [1:0] {
    ALU_ADD = 2'h0,
    ALU_AND = 2'h1,
    ALU_DEC = 2'h2,
    ALU_CLR = 2'h3
  } ies_alu_op_t;

  // ********************************************************************
  // carriers and state
  // ********************************************************************
  typedef struct packed {
    logic [6:0] addr;
    logic [7:0] wdata;
    logic we;
  } ies_file_req_t;

  typedef struct packed {
    logic [7:0] res;
    logic carry;
    logic nib;
    logic zero;
  } ies_alu_out_t;

  typedef struct packed {
    logic [STACK_DEPTH-1:0][PC_W-1:0] mem;
    logic [2:0] ptr;
    logic [3:0] level;
  } ies_stack_state_t;

  typedef struct packed {
    ies_phase_t phase;
    logic run;
    logic [PC_W-1:0] pc;
    logic [WORD_W-1:0] ir;
    logic [7:0] opnd;
    logic [7:0] w;
    logic c;
    logic dc;
    logic z;
    logic [4:0] ujl;
    logic illegal;
    ies_alu_out_t res;
    logic cond;
    logic [7:0] fwdata;
    logic fwe;
    logic [31:0] prdata;
  } ies_core_state_t;

endpackage : ies_pkg

// ==== hw/ies_alu.sv ====
module ies_alu (
  // operation select
  input wire ies_pkg::ies_alu_op_t op_in,
  // operands
  input wire logic [7:0] a_in,
  input wire logic [7:0] b_in,
  // result with flags
  output ies_pkg::ies_alu_out_t out_out
);

  logic [8:0] sum;
  logic [4:0] nib_sum;

  // carries taken from the widened sums, not from the truncated byte
  always_comb begin
    sum = {1'b0, a_in} + {1'b0, b_in};
    nib_sum = {1'b0, a_in[3:0]} + {1'b0, b_in[3:0]};
    out_out = '0;
    case (op_in)
      ies_pkg::ALU_ADD: begin
        out_out.res = sum[7:0];
        out_out.carry = sum[8];
        out_out.nib = nib_sum[4];
      end
      ies_pkg::ALU_AND: out_out.res = a_in & b_in;
      ies_pkg::ALU_DEC: out_out.res = b_in - 8'h01;
      default: out_out.res = 8'h00;
    endcase
    out_out.zero = (out_out.res == 8'h00);
  end

endmodule : ies_alu

// ==== hw/ies_return_stack.sv ====
module ies_return_stack (
  // clock, reset, enable
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic ce_in,
  // push side
  input wire logic push_in,
  input wire logic [ies_pkg::PC_W-1:0] data_in,
  // observation
  output logic [ies_pkg::PC_W-1:0] top_out,
  output logic [3:0] level_out
);

  ies_pkg::ies_stack_state_t cur;
  ies_pkg::ies_stack_state_t next_cur;

  // circular store: a ninth push overwrites the oldest entry silently
  always_comb begin
    next_cur = cur;
    if (push_in) begin
      next_cur.mem[cur.ptr] = data_in;
      next_cur.ptr = cur.ptr + 3'h1;
      if (cur.level != 4'(ies_pkg::STACK_DEPTH)) begin
        next_cur.level = cur.level + 4'h1;
      end
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      cur <= '0;
    end else if (ce_in) begin
      cur <= next_cur;
    end
  end

  // head entry sits one below the write pointer
  assign top_out = cur.mem[cur.ptr - 3'h1];
  assign level_out = cur.level;

endmodule : ies_return_stack

// ==== hw/ies_core.sv ====
module ies_core (
  // clock, reset, enable
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic ce_in,
  // apb slave
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [11:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  input wire logic [3:0] pstrb_in,
  output logic pready_out,
  output logic pslverr_out,
  output logic [31:0] prdata_out,
  // program memory fetch
  output logic [ies_pkg::PC_W-1:0] prog_addr_out,
  input wire logic [ies_pkg::WORD_W-1:0] prog_word_in,
  // file register port
  output ies_pkg::ies_file_req_t file_req_out,
  input wire logic [7:0] file_rdata_in
);

  // ********************************************************************
  // state and helpers
  // ********************************************************************
  // core state apart from the return stack lives in one registered struct
  ies_pkg::ies_core_state_t cur;
  ies_pkg::ies_core_state_t next_cur;
  // decode result and datapath wiring
  ies_pkg::ies_op_t op;
  ies_pkg::ies_alu_op_t alu_op;
  ies_pkg::ies_alu_out_t alu_out;
  logic [7:0] alu_b;
  // return stack view and push strobe
  logic [ies_pkg::PC_W-1:0] stk_top;
  logic [3:0] stk_level;
  logic push;
  logic dest_file;
  // bus decode helpers
  logic mapped;
  logic wr;
  logic [31:0] rd_mux;

  // ********************************************************************
  // decode
  // ********************************************************************
  // only the fixed opcode bits are compared, x positions never matter
  // the fixed fields of the eight patterns never overlap, so the order is free
  always_comb begin
    op = ies_pkg::OP_OTHER;
    if (cur.ir[13:9] == ies_pkg::OPC_ADD_LIT) begin
      op = ies_pkg::OP_ADD_LIT;
    end else if (cur.ir[13:8] == ies_pkg::OPC_AND_LIT) begin
      op = ies_pkg::OP_AND_LIT;
    end else if (cur.ir[13:8] == ies_pkg::OPC_ADD_FILE) begin
      op = ies_pkg::OP_ADD_FILE;
    end else if (cur.ir[13:8] == ies_pkg::OPC_AND_FILE) begin
      op = ies_pkg::OP_AND_FILE;
    end else if (cur.ir[13:10] == ies_pkg::OPC_BIT_SKIP) begin
      op = ies_pkg::OP_BIT_SKIP;
    end else if (cur.ir[13:11] == ies_pkg::OPC_CALL) begin
      op = ies_pkg::OP_CALL;
    end else if (cur.ir[13:7] == ies_pkg::OPC_CLR_FILE) begin
      op = ies_pkg::OP_CLR_FILE;
    end else if (cur.ir[13:8] == ies_pkg::OPC_DEC_SKIP) begin
      op = ies_pkg::OP_DEC_SKIP;
    end else if (cur.ir[13:7] == 7'h00 && cur.ir[4:0] == 5'h00) begin
      op = ies_pkg::OP_NOP; // x bits 6:5 ignored
    end
  end

  // operand and alu function per instruction
  // literal forms take the low byte of the word, file forms the operand read in Q2
  always_comb begin
    alu_b = cur.opnd;
    alu_op = ies_pkg::ALU_AND;
    case (op)
      ies_pkg::OP_ADD_LIT: begin
        alu_b = cur.ir[7:0];
        alu_op = ies_pkg::ALU_ADD;
      end
      ies_pkg::OP_AND_LIT: alu_b = cur.ir[7:0];
      ies_pkg::OP_ADD_FILE: alu_op = ies_pkg::ALU_ADD;
      ies_pkg::OP_CLR_FILE: alu_op = ies_pkg::ALU_CLR;
      ies_pkg::OP_DEC_SKIP: alu_op = ies_pkg::ALU_DEC;
      default: alu_op = ies_pkg::ALU_AND;
    endcase
  end

  // flag logic kept in one place so every add reports its carries alike
  ies_alu u_alu (
    .op_in(alu_op),
    .a_in(cur.w),
    .b_in(alu_b),
    .out_out(alu_out)
  );

  // pushed value is the already incremented pc, i.e. the return address
  ies_return_stack u_stack (
    .clk_in(clk_in),
    .resetn_in(resetn_in),
    .ce_in(ce_in),
    .push_in(push),
    .data_in(cur.pc),
    .top_out(stk_top),
    .level_out(stk_level)
  );

  // destination select: 0 keeps the result in the accumulator
  assign dest_file = cur.ir[ies_pkg::DEST_BIT];

  // ********************************************************************
  // apb decode
  // ********************************************************************
  always_comb begin
    mapped = 1'b1;
    rd_mux = 32'h0000_0000;
    // unlisted bits and addresses read as zero
    case (paddr_in)
      ies_pkg::A_CTRL: rd_mux[ies_pkg::CTRL_RUN_BIT] = cur.run;
      ies_pkg::A_STATUS: begin
        rd_mux[ies_pkg::ST_C_BIT] = cur.c;
        rd_mux[ies_pkg::ST_DC_BIT] = cur.dc;
        rd_mux[ies_pkg::ST_Z_BIT] = cur.z;
        rd_mux[ies_pkg::ST_ILL_BIT] = cur.illegal;
        rd_mux[ies_pkg::ST_PH_LSB +: 2] = cur.phase;
      end
      ies_pkg::A_ACC: rd_mux[7:0] = cur.w;
      ies_pkg::A_PC: rd_mux[ies_pkg::PC_W-1:0] = cur.pc;
      ies_pkg::A_UJL: rd_mux[4:0] = cur.ujl;
      ies_pkg::A_STACK: begin
        rd_mux[3:0] = stk_level;
        rd_mux[ies_pkg::STK_TOP_LSB +: ies_pkg::PC_W] = stk_top;
      end
      default: mapped = 1'b0;
    endcase
  end

  // zero wait states while enabled; a frozen block stalls the bus
  // error only in the access phase, so a setup cycle never flags
  assign pready_out = ce_in;
  assign pslverr_out = psel_in & penable_in & ~mapped;
  assign wr = psel_in & penable_in & pwrite_in & mapped;

  // ********************************************************************
  // next state
  // ********************************************************************
  always_comb begin
    next_cur = cur;
    push = 1'b0;
    next_cur.fwe = 1'b0;
    // read data is sampled in the setup cycle and held for the access
    if (psel_in && !penable_in) begin
      next_cur.prdata = rd_mux;
    end
    // register writes; accumulator, pc and flags only while halted; the sticky-bit clear acts anytime, the clear bit fully only while halted
    // halting is the only safe moment to load the accumulator, pc or flags
    if (wr && pstrb_in[0]) begin
      case (paddr_in)
        ies_pkg::A_CTRL: begin
          next_cur.run = pwdata_in[ies_pkg::CTRL_RUN_BIT];
          if (pwdata_in[ies_pkg::CTRL_CLR_BIT]) begin
            next_cur.phase = ies_pkg::PH_Q1;
            next_cur.pc = ies_pkg::RST_PC;
            next_cur.ir = ies_pkg::NOP_WORD;
          end
        end
        ies_pkg::A_STATUS: begin
          if (!cur.run) begin
            next_cur.c = pwdata_in[ies_pkg::ST_C_BIT];
            next_cur.dc = pwdata_in[ies_pkg::ST_DC_BIT];
            next_cur.z = pwdata_in[ies_pkg::ST_Z_BIT];
          end
          // write one to clear; a new event later this cycle wins
          if (pwdata_in[ies_pkg::ST_ILL_BIT]) begin
            next_cur.illegal = 1'b0;
          end
        end
        ies_pkg::A_ACC: begin
          if (!cur.run) begin
            next_cur.w = pwdata_in[7:0];
          end
        end
        ies_pkg::A_PC: begin
          if (!cur.run) begin
            next_cur.pc[7:0] = pwdata_in[7:0];
          end
        end
        ies_pkg::A_UJL: next_cur.ujl = pwdata_in[4:0];
        default: next_cur.ujl = cur.ujl;
      endcase
    end
    if (wr && pstrb_in[1] && paddr_in == ies_pkg::A_PC && !cur.run) begin
      next_cur.pc[12:8] = pwdata_in[12:8];
    end

    // four clock phases make one instruction cycle
    if (cur.run) begin
      case (cur.phase)
        ies_pkg::PH_Q1: begin
          // file address from the new word settles during this phase
          next_cur.phase = ies_pkg::PH_Q2;
        end
        ies_pkg::PH_Q2: begin
          // file address has been stable since Q1
          next_cur.opnd = file_rdata_in;
          next_cur.phase = ies_pkg::PH_Q3;
        end
        ies_pkg::PH_Q3: begin
          next_cur.res = alu_out;
          next_cur.fwdata = alu_out.res;
          next_cur.cond = 1'b0;
          case (op)
            ies_pkg::OP_ADD_FILE, ies_pkg::OP_AND_FILE: begin
              next_cur.fwe = dest_file;
            end
            ies_pkg::OP_DEC_SKIP: begin
              next_cur.fwe = dest_file;
              next_cur.cond = alu_out.zero;
            end
            ies_pkg::OP_CLR_FILE: begin
              next_cur.fwe = 1'b1; // zero written
            end
            ies_pkg::OP_BIT_SKIP: begin
              next_cur.cond = cur.opnd[cur.ir[9:7]];
            end
            default: next_cur.fwe = 1'b0;
          endcase
          next_cur.phase = ies_pkg::PH_Q4;
        end
        ies_pkg::PH_Q4: begin
          // commit results; pc already points past this instruction
          next_cur.ir = prog_word_in;
          next_cur.pc = cur.pc + 13'h0001;
          case (op)
            ies_pkg::OP_ADD_LIT: begin
              next_cur.w = cur.res.res;
              next_cur.c = cur.res.carry;
              next_cur.dc = cur.res.nib;
              next_cur.z = cur.res.zero;
            end
            ies_pkg::OP_AND_LIT: begin
              next_cur.w = cur.res.res;
              next_cur.z = cur.res.zero;
            end
            ies_pkg::OP_ADD_FILE: begin
              if (!dest_file) begin
                next_cur.w = cur.res.res;
              end
              next_cur.c = cur.res.carry;
              next_cur.dc = cur.res.nib;
              next_cur.z = cur.res.zero;
            end
            ies_pkg::OP_AND_FILE: begin
              if (!dest_file) begin
                next_cur.w = cur.res.res;
              end
              next_cur.z = cur.res.zero;
            end
            ies_pkg::OP_CLR_FILE: begin
              next_cur.z = 1'b1;
            end
            ies_pkg::OP_DEC_SKIP: begin
              if (!dest_file) begin
                next_cur.w = cur.res.res; // flags untouched
              end
              if (cur.cond) begin
                next_cur.ir = ies_pkg::NOP_WORD;
              end
            end
            ies_pkg::OP_BIT_SKIP: begin
              if (cur.cond) begin
                next_cur.ir = ies_pkg::NOP_WORD;
              end
            end
            ies_pkg::OP_CALL: begin
              // prefetched word dropped, target fetched next cycle
              push = 1'b1;
              next_cur.ir = ies_pkg::NOP_WORD;
              next_cur.pc = {cur.ujl[ies_pkg::UJL_HI:ies_pkg::UJL_LO],
                             cur.ir[10:0]};
            end
            ies_pkg::OP_OTHER: begin
              // unsupported words run as a no-op but leave a trace
              next_cur.illegal = 1'b1;
            end
            ies_pkg::OP_NOP: begin
              // nothing to commit; a pending clear of the sticky bit must survive
              push = 1'b0;
            end
            default: push = 1'b0;
          endcase
          next_cur.phase = ies_pkg::PH_Q1;
        end
        default: next_cur.phase = ies_pkg::PH_Q1;
      endcase
    end
  end

  // ********************************************************************
  // state register
  // ********************************************************************
  // every field clears to zero first, then the named reset values are loaded
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      cur <= '0;
      cur.phase <= ies_pkg::PH_Q1;
      cur.pc <= ies_pkg::RST_PC;
      cur.ir <= ies_pkg::NOP_WORD;
      cur.w <= ies_pkg::RST_W;
      cur.ujl <= ies_pkg::RST_UJL;
    end else if (ce_in) begin
      cur <= next_cur;
    end
  end

  // ********************************************************************
  // outputs
  // ********************************************************************
  // registered read data holds until the next setup cycle
  assign prdata_out = cur.prdata;
  // fetch address is the pc, which already points past the executing word
  assign prog_addr_out = cur.pc;
  // file port: address from the word, write pulse during Q4 only
  assign file_req_out.addr = cur.ir[6:0];
  assign file_req_out.wdata = cur.fwdata;
  assign file_req_out.we = cur.fwe;

endmodule : ies_core

// ==== test/ies_core_props.sv ====
module ies_core_props (
  // clock and reset
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic ce_in,
  // apb side
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [11:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  input wire logic [3:0] pstrb_in,
  input wire logic pready_out,
  input wire logic pslverr_out,
  input wire logic [31:0] prdata_out,
  // fetch and file port
  input wire logic [ies_pkg::PC_W-1:0] prog_addr_out,
  input wire logic [ies_pkg::WORD_W-1:0] prog_word_in,
  input wire ies_pkg::ies_file_req_t file_req_out,
  input wire logic [7:0] file_rdata_in
);
  timeunit 1ns;
  timeprecision 1ps;
  // ********************************************************************
  // word history: slot 3 is the executing word when the write pulse shows
  // ********************************************************************
  logic [4:0][13:0] word_hist;

  // shift every clock; halts mid-instruction would skew this, so tests halt only in loops
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      word_hist <= '0;
    end else begin
      word_hist <= {word_hist[3:0], prog_word_in};
    end
  end

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!resetn_in);

  // ********************************************************************
  // properties
  // ********************************************************************
  sequence s_call_latched;
    $changed(prog_addr_out) && word_hist[0][13:11] == ies_pkg::OPC_CALL;
  endsequence
  sequence s_pc_quiet;
    $stable(prog_addr_out) [*3];
  endsequence

  property p_insn_len;
    $changed(prog_addr_out) |=> s_pc_quiet;
  endproperty
  property p_we_pulse;
    file_req_out.we |=> !file_req_out.we [*3];
  endproperty
  property p_we_addr;
    file_req_out.we |-> file_req_out.addr == word_hist[3][6:0] && $stable(file_req_out.addr);
  endproperty
  property p_we_dest;
    file_req_out.we |-> word_hist[3][ies_pkg::DEST_BIT];
  endproperty
  property p_clr_zero;
    file_req_out.we && word_hist[3][13:7] == ies_pkg::OPC_CLR_FILE |-> file_req_out.wdata == 8'h00;
  endproperty
  property p_dec_value;
    file_req_out.we && word_hist[3][13:8] == ies_pkg::OPC_DEC_SKIP
      |-> file_req_out.wdata == 8'($past(file_rdata_in, 2) - 8'h01);
  endproperty
  property p_dec_skip;
    file_req_out.we && word_hist[3][13:8] == ies_pkg::OPC_DEC_SKIP && file_req_out.wdata == 8'h00
      |=> !file_req_out.we [*7];
  endproperty
  property p_call_target;
    s_call_latched ##1 s_pc_quiet ##1 $changed(prog_addr_out)
      |-> prog_addr_out[10:0] == word_hist[4][10:0];
  endproperty
  property p_call_nop;
    s_call_latched |-> !file_req_out.we [*8];
  endproperty

  a_insn_len: assert property (p_insn_len) else $error("pc moved mid instruction");
  a_we_pulse: assert property (p_we_pulse) else $error("file write pulse too long");
  a_we_addr: assert property (p_we_addr) else $error("file address not from word");
  a_we_dest: assert property (p_we_dest) else $error("file written with dest clear");
  a_clr_zero: assert property (p_clr_zero) else $error("clear wrote nonzero");
  a_dec_value: assert property (p_dec_value) else $error("decrement value wrong");
  a_dec_skip: assert property (p_dec_skip) else $error("skipped word was executed");
  a_call_target: assert property (p_call_target) else $error("call target wrong");
  a_call_nop: assert property (p_call_nop) else $error("word after call executed");
endmodule : ies_core_props

bind ies_core ies_core_props u_props (.clk_in(clk_in), .resetn_in(resetn_in), .ce_in(ce_in),
  .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
  .pwdata_in(pwdata_in), .pstrb_in(pstrb_in), .pready_out(pready_out),
  .pslverr_out(pslverr_out), .prdata_out(prdata_out), .prog_addr_out(prog_addr_out),
  .prog_word_in(prog_word_in), .file_req_out(file_req_out), .file_rdata_in(file_rdata_in));

// ==== test/testbench.sv ====
module testbench;
  timeunit 1ns;
  timeprecision 1ps;

  logic clk_in;
  logic resetn_in;
  logic psel_in, penable_in, pwrite_in, pready_out, pslverr_out;
  logic [11:0] paddr_in;
  logic [31:0] pwdata_in, prdata_out, rv;
  logic [ies_pkg::PC_W-1:0] prog_addr_out;
  logic [ies_pkg::WORD_W-1:0] prog_word_in;
  ies_pkg::ies_file_req_t file_req_out;
  logic [7:0] file_rdata_in;
  logic [13:0] pmem [8192];
  logic [7:0] fmem [128];
  int wtime [128];
  int cyc = 0;
  int fail_count = 0;
  int n_tests = 0;
  logic [13:0] prog1 [13] = '{14'h01A0, 14'h3FF8, 14'h07A5, 14'h0526, 14'h0BA2, 14'h01A3,
    14'h1EA6, 14'h01A7, 14'h1D26, 14'h0B28, 14'h3903, 14'h01A9, 14'h2010};

  // program memory and file space answer combinationally
  assign prog_word_in = pmem[prog_addr_out];
  assign file_rdata_in = fmem[file_req_out.addr];

  ies_core DUT (.clk_in(clk_in), .resetn_in(resetn_in), .ce_in(1'h1), .psel_in(psel_in),
    .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in),
    .pstrb_in(4'hF), .pready_out(pready_out), .pslverr_out(pslverr_out),
    .prdata_out(prdata_out), .prog_addr_out(prog_addr_out), .prog_word_in(prog_word_in),
    .file_req_out(file_req_out), .file_rdata_in(file_rdata_in));

  initial begin
    clk_in = 1'h0;
    forever #5 clk_in = ~clk_in;
  end

  // ********************************************************************
  // file model, write timestamps and hang guard
  // ********************************************************************
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if (file_req_out.we === 1'h1) begin
      fmem[file_req_out.addr] <= file_req_out.wdata;
      wtime[file_req_out.addr] <= cyc;
    end
    if (cyc == 20000) begin
      fail_count++;
      tally_and_finish();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic tally_and_finish();
    $display("checks=%0d mismatches=%0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : tally_and_finish

  // one apb transfer; request held until pready is seen at a rising edge
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    @(posedge clk_in);
    psel_in <= 1'h1;
    penable_in <= 1'h0;
    pwrite_in <= wr;
    paddr_in <= a;
    pwdata_in <= wd;
    @(posedge clk_in);
    penable_in <= 1'h1;
    do @(posedge clk_in); while (pready_out !== 1'h1);
    rd = prdata_out;
    err = pslverr_out;
    psel_in <= 1'h0;
    penable_in <= 1'h0;
  endtask : apb

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'h1, a, d, r, e);
  endtask : wr

  task automatic rd(input logic [11:0] a, output logic [31:0] r);
    logic e;
    apb(1'h0, a, 32'h0, r, e);
  endtask : rd

  // halt is issued only while the program sits in its closing call loop
  task automatic run_prog(input logic [7:0] w);
    wr(ies_pkg::A_CTRL, 32'h2);
    wr(ies_pkg::A_ACC, {24'h0, w});
    wr(ies_pkg::A_STATUS, 32'h0);
    wr(ies_pkg::A_UJL, 32'h8);
    wr(ies_pkg::A_CTRL, 32'h1);
    wr(ies_pkg::A_ACC, 32'hAA);
    repeat (160) @(posedge clk_in);
    wr(ies_pkg::A_CTRL, 32'h0);
  endtask : run_prog

  // ********************************************************************
  // main sequence
  // ********************************************************************
  initial begin
    logic e;
    resetn_in = 1'h0;
    psel_in = 1'h0;
    penable_in = 1'h0;
    pwrite_in = 1'h0;
    paddr_in = 12'h0;
    pwdata_in = 32'h0;
    foreach (pmem[i]) pmem[i] = 14'h0;
    foreach (fmem[i]) fmem[i] = 8'h0;
    repeat (5) @(posedge clk_in);
    resetn_in <= 1'h1;
    // reset values, then an unmapped read
    for (int i = 0; i < 6; i++) begin
      rd(12'(4 * i), rv);
      check(rv, 32'h0);
    end
    apb(1'h0, 12'h030, 32'h0, rv, e);
    check({31'h0, e}, 32'h1);
    check(rv, 32'h0);
    // program 1: every subset instruction, four skip tests (two taken), call into upper page
    foreach (prog1[i]) pmem[i] = prog1[i];
    pmem[13'h0810] = 14'h2010;
    fmem[8'h20] = 8'hEE;
    fmem[8'h25] = 8'hF0;
    fmem[8'h26] = 8'h33;
    fmem[8'h22] = 8'h01;
    fmem[8'h23] = 8'h77;
    fmem[8'h27] = 8'h55;
    fmem[8'h28] = 8'h05;
    fmem[8'h29] = 8'h99;
    run_prog(8'h18);
    rd(ies_pkg::A_ACC, rv);
    check(rv, 32'h0);
    rd(ies_pkg::A_STATUS, rv);
    check(rv & 32'hF, 32'h5);
    rd(ies_pkg::A_STACK, rv);
    check(rv, 32'h0811_0008);
    check(fmem[8'h20], 32'h0);
    check(fmem[8'h25], 32'h0);
    check(fmem[8'h26], 32'h33);
    check(fmem[8'h22], 32'h0);
    check(fmem[8'h23], 32'h77);
    check(fmem[8'h27], 32'h55);
    check(fmem[8'h28], 32'h05);
    check(fmem[8'h29], 32'h0);
    check(32'(wtime[8'h25] - wtime[8'h20]), 32'h8);
    check(32'(wtime[8'h29] - wtime[8'h22]), 32'h1C);
    // program 2: literal add with the loose bit clear, an unsupported word, then a call
    // whose dropped successor would clear 0x26
    pmem[0] = 14'h3EF8;
    pmem[1] = 14'h3C00;
    pmem[2] = 14'h2010;
    pmem[3] = 14'h01A6;
    run_prog(8'h18);
    rd(ies_pkg::A_ACC, rv);
    check(rv, 32'h10);
    rd(ies_pkg::A_STATUS, rv);
    check(rv & 32'hF, 32'hB);
    check(fmem[8'h26], 32'h33);
    // sticky bit is write-one-to-clear; flags are rewritten while halted
    wr(ies_pkg::A_STATUS, 32'hB);
    rd(ies_pkg::A_STATUS, rv);
    check(rv & 32'hF, 32'h3);
    tally_and_finish();
  end
endmodule : testbench
